//--- serial_card_ctrl_status_port.sv
// Purpose: Address decode, control/status port and TC latch
// Assumes: Bus strobes are one-cycle pulses synchronous to i_core_clk
// Notes: Read data is registered, valid the cycle after the strobe
// Operation
// - Eight addresses; fifth is control/status
// - Write bit 0 sets terminal ready
// - Write bit 7 sets DMA enable
// - Read bit 0 is DSR, active low
// - Read bit 3 is controller IRQ, low
// - Read bit 5 is TC latch, low
// - Read bit 7 is DMA state, low
// - TC pulse sets latch when option selected
// - Set latch drives card interrupt request
// - Any write to sixth address clears latch unless a TC sets it in that cycle
// - Reset clears software DMA enable
// - Select chooses DMA driver enable source
// - Base matches A9..A3 against switches
// - Offsets 0-3 map to controller ports
`timescale 1ns/1ps
`include "serial_card_defs.svh"
module serial_card_ctrl_status_port
	import serial_card_pkg::*;
(
	input wire logic i_core_clk,
	input wire logic i_arst_n,
	input wire logic [9:0] i_io_addr,
	input wire logic i_io_wr,
	input wire logic i_io_rd,
	input wire logic [7:0] i_io_wdata,
	input wire logic [6:0] i_base_switch_open,
	input wire logic i_dsr,
	input wire logic i_serial_ctrl_irq_n,
	input wire logic i_dma_tc,
	input wire logic i_irq_mode_select,
	input wire dma_src_e i_dma_enable_source_select,
	input wire logic i_chan_b_rts,
	output logic o_card_sel,
	output logic o_serial_ctrl_cs,
	output logic [1:0] o_serial_ctrl_reg,
	output logic [7:0] o_io_rdata,
	output logic o_io_rdata_oe,
	output logic o_dtr,
	output logic o_dma_drv_en,
	output logic o_tc_interrupt
);
	logic dtr_ff;
	logic dma_sw_en_ff;
	logic tc_latch_ff;
	logic [7:0] rdata_ff;
	logic rdata_oe_ff;
	logic dma_on;
	logic csr_wr;
	logic tc_clr;
	logic [2:0] ofs;

	// Local offset decoder, shared by several strobes
	function automatic logic hit(input logic [2:0] o, input logic [2:0] t);
		hit = (o == t);
	endfunction : hit

	// Base compare; open switch needs a one
	assign o_card_sel = (i_io_addr[9:3] == i_base_switch_open);
	assign ofs = i_io_addr[2:0];
	// Low four offsets go to the controller
	assign o_serial_ctrl_cs = o_card_sel && (ofs[2] == 1'b0);
	assign o_serial_ctrl_reg = ofs[1:0];
	assign csr_wr = o_card_sel && i_io_wr && hit(ofs, `OFS_CTRL_STATUS);
	assign tc_clr = o_card_sel && i_io_wr && hit(ofs, `OFS_TC_CLEAR);

	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			dtr_ff <= `DTR_RESET;
		end else if (csr_wr) begin
			dtr_ff <= i_io_wdata[`BIT_DTR];
		end
	end

	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			dma_sw_en_ff <= `DMA_EN_RESET;
		end else if (csr_wr) begin
			dma_sw_en_ff <= i_io_wdata[`BIT_DMA];
		end
	end

	// TC latch; a TC in the clearing cycle wins
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			tc_latch_ff <= 1'b0;
		end else if (i_irq_mode_select && i_dma_tc) begin
			tc_latch_ff <= 1'b1;
		end else if (tc_clr) begin
			tc_latch_ff <= 1'b0;
		end
	end

	always_comb begin
		case (i_dma_enable_source_select)
			DMA_SRC_CSR_BIT: dma_on = dma_sw_en_ff;
			DMA_SRC_CHAN_B_RTS: dma_on = i_chan_b_rts;
			DMA_SRC_ALWAYS: dma_on = 1'b1;
			default: dma_on = 1'b0;
		endcase
	end

	// Status is sampled at the strobe so a slow host sees a stable byte
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rdata_ff <= 8'h00;
			rdata_oe_ff <= 1'b0;
		end else begin
			rdata_oe_ff <= o_card_sel && i_io_rd && hit(ofs, `OFS_CTRL_STATUS);
			if (o_card_sel && i_io_rd && hit(ofs, `OFS_CTRL_STATUS)) begin
				rdata_ff <= 8'h00;
				rdata_ff[`BIT_DSR] <= ~i_dsr;
				rdata_ff[`BIT_SERIAL_IRQ] <= i_serial_ctrl_irq_n;
				rdata_ff[`BIT_TC_LATCH] <= ~tc_latch_ff;
				rdata_ff[`BIT_DMA] <= ~dma_on;
			end
		end
	end

	assign o_io_rdata = rdata_ff;
	assign o_io_rdata_oe = rdata_oe_ff;
	assign o_dtr = dtr_ff;
	assign o_dma_drv_en = dma_on;
	assign o_tc_interrupt = tc_latch_ff;

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_arst_n);

	sequence s_csr_write;
		csr_wr;
	endsequence
	sequence s_tc_clear_only;
		tc_clr && !(i_irq_mode_select && i_dma_tc);
	endsequence
	sequence s_no_status_read;
		!(o_card_sel && i_io_rd && ofs == `OFS_CTRL_STATUS);
	endsequence
	sequence s_after_reset;
		$rose(i_arst_n);
	endsequence

	property p_dtr_write;
		s_csr_write |=> (o_dtr == $past(i_io_wdata[0]));
	endproperty
	a_dtr_write: assert property (p_dtr_write)
		else $error("terminal ready not taken from bit 0");

	property p_dma_write;
		s_csr_write |=> (dma_sw_en_ff == $past(i_io_wdata[7]));
	endproperty
	a_dma_write: assert property (p_dma_write)
		else $error("dma enable not taken from bit 7");

	property p_dsr_read;
		(o_card_sel && i_io_rd && ofs == 3'h4) |=>
			(o_io_rdata_oe && o_io_rdata[0] == !$past(i_dsr));
	endproperty
	a_dsr_read: assert property (p_dsr_read)
		else $error("dsr read bit wrong");

	property p_irq_read;
		(o_card_sel && i_io_rd && ofs == 3'h4) |=>
			(o_io_rdata[3] == $past(i_serial_ctrl_irq_n));
	endproperty
	a_irq_read: assert property (p_irq_read)
		else $error("controller irq read bit wrong");

	property p_tc_read;
		(o_card_sel && i_io_rd && ofs == 3'h4) |=>
			(o_io_rdata[5] == !$past(tc_latch_ff));
	endproperty
	a_tc_read: assert property (p_tc_read)
		else $error("tc status read bit wrong");

	property p_dma_read;
		(o_card_sel && i_io_rd && ofs == 3'h4) |=>
			(o_io_rdata[7] == !$past(dma_on));
	endproperty
	a_dma_read: assert property (p_dma_read)
		else $error("dma state read bit wrong");

	property p_tc_set;
		(i_irq_mode_select && i_dma_tc) |=> o_tc_interrupt;
	endproperty
	a_tc_set: assert property (p_tc_set)
		else $error("tc latch did not set");

	property p_tc_hold;
		(!i_irq_mode_select || !i_dma_tc) && !o_tc_interrupt |=>
			!o_tc_interrupt;
	endproperty
	a_tc_hold: assert property (p_tc_hold)
		else $error("interrupt rose without tc");

	property p_tc_clear;
		s_tc_clear_only |=> !o_tc_interrupt;
	endproperty
	a_tc_clear: assert property (p_tc_clear)
		else $error("tc latch not cleared");

	property p_dma_src;
		(i_dma_enable_source_select == DMA_SRC_NONE) |-> !o_dma_drv_en;
	endproperty
	a_dma_src: assert property (p_dma_src)
		else $error("dma drivers on while unselected");

	property p_base;
		o_serial_ctrl_cs |-> (i_io_addr[9:3] == i_base_switch_open
			&& !i_io_addr[2]);
	endproperty
	a_base: assert property (p_base)
		else $error("controller selected outside window");

	property p_reset_dma;
		s_after_reset |-> !dma_sw_en_ff;
	endproperty
	a_reset_dma: assert property (p_reset_dma)
		else $error("dma enable not cleared by reset");

	property p_reset_dtr;
		s_after_reset |-> !o_dtr;
	endproperty
	a_reset_dtr: assert property (p_reset_dtr)
		else $error("terminal ready not cleared by reset");

	property p_reset_tc;
		s_after_reset |-> (!o_tc_interrupt && !o_io_rdata_oe);
	endproperty
	a_reset_tc: assert property (p_reset_tc)
		else $error("interrupt or read strobe left on by reset");

	property p_dtr_hold;
		!csr_wr |=> $stable(o_dtr);
	endproperty
	a_dtr_hold: assert property (p_dtr_hold)
		else $error("terminal ready changed without a write");

	property p_dma_hold;
		!csr_wr |=> $stable(dma_sw_en_ff);
	endproperty
	a_dma_hold: assert property (p_dma_hold)
		else $error("dma enable changed without a write");

	property p_oe_only_read;
		s_no_status_read |=> !o_io_rdata_oe;
	endproperty
	a_oe_only_read: assert property (p_oe_only_read)
		else $error("read strobe without a status read");

	property p_rdata_hold;
		s_no_status_read |=> $stable(o_io_rdata);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold)
		else $error("status byte changed without a read");

	property p_unused_zero;
		o_io_rdata_oe |->
			((o_io_rdata & `STATUS_UNUSED_MASK) == 8'h00);
	endproperty
	a_unused_zero: assert property (p_unused_zero)
		else $error("unused status bits not zero");

	property p_tc_keep;
		(o_tc_interrupt && !tc_clr) |=> o_tc_interrupt;
	endproperty
	a_tc_keep: assert property (p_tc_keep)
		else $error("interrupt dropped without a clear");

	property p_dma_csr;
		(i_dma_enable_source_select == DMA_SRC_CSR_BIT) |->
			(o_dma_drv_en == dma_sw_en_ff);
	endproperty
	a_dma_csr: assert property (p_dma_csr)
		else $error("dma drivers not following enable bit");

	property p_dma_rts;
		(i_dma_enable_source_select == DMA_SRC_CHAN_B_RTS) |->
			(o_dma_drv_en == i_chan_b_rts);
	endproperty
	a_dma_rts: assert property (p_dma_rts)
		else $error("dma drivers not following channel b rts");

	property p_dma_always;
		(i_dma_enable_source_select == DMA_SRC_ALWAYS) |-> o_dma_drv_en;
	endproperty
	a_dma_always: assert property (p_dma_always)
		else $error("dma drivers off while always selected");

	property p_ctrl_reg;
		o_serial_ctrl_cs |-> (o_serial_ctrl_reg == i_io_addr[1:0]);
	endproperty
	a_ctrl_reg: assert property (p_ctrl_reg)
		else $error("controller register offset wrong");

	property p_cs_upper;
		(o_card_sel && i_io_addr[2]) |-> !o_serial_ctrl_cs;
	endproperty
	a_cs_upper: assert property (p_cs_upper)
		else $error("controller selected on board offsets");

	property p_window;
		(i_io_addr[9:3] == i_base_switch_open) |-> o_card_sel;
	endproperty
	a_window: assert property (p_window)
		else $error("window address not answered");
endmodule : serial_card_ctrl_status_port

//--- serial_card_defs.svh
// Purpose: Constants for the serial card control/status port
// Assumes: Byte-wide PC I/O bus, ten address bits
// Notes: Offsets are relative to the switch-selected base
`ifndef SERIAL_CARD_DEFS_SVH
`define SERIAL_CARD_DEFS_SVH
`define OFS_CHAN_A_DATA 3'h0
`define OFS_CHAN_A_CTRL 3'h1
`define OFS_CHAN_B_DATA 3'h2
`define OFS_CHAN_B_CTRL 3'h3
`define OFS_CTRL_STATUS 3'h4
`define OFS_TC_CLEAR 3'h5
`define BIT_DTR 0
`define BIT_DSR 0
`define BIT_SERIAL_IRQ 3
`define BIT_TC_LATCH 5
`define BIT_DMA 7
`define DTR_RESET 1'b0
`define DMA_EN_RESET 1'b0
`define STATUS_UNUSED_MASK 8'h56
`endif

//--- serial_card_pkg.sv
// Purpose: Types for the serial card control/status port
// Assumes: Constants live in serial_card_defs.svh
// Notes: Select codes follow the enable header positions
package serial_card_pkg;
	typedef enum logic [1:0] {
		DMA_SRC_NONE,
		DMA_SRC_CSR_BIT,
		DMA_SRC_CHAN_B_RTS,
		DMA_SRC_ALWAYS
	} dma_src_e;
endpackage : serial_card_pkg

//--- serial_card_host.sv
// Purpose: Host model issuing byte I/O cycles
// Assumes: Strobes last one cycle, set at falling edges
// Notes: Idle lines show inverted values, never stale ones
`timescale 1ns/1ps
module serial_card_host (
	input wire logic i_core_clk,
	output logic [9:0] o_io_addr = 10'h000,
	output logic o_io_wr = 1'b0,
	output logic o_io_rd = 1'b0,
	output logic [7:0] o_io_wdata = 8'h00
);
	task automatic cyc(input logic [9:0] a, input logic w,
		input logic [7:0] d);
		@(negedge i_core_clk);
		o_io_addr = a;
		o_io_wr = w;
		o_io_rd = !w;
		o_io_wdata = d;
		@(negedge i_core_clk);
		{o_io_wr, o_io_rd} = 2'b00;
		o_io_addr = ~a;
		o_io_wdata = ~d;
	endtask : cyc
	// Clear from service routine, any data
	task automatic clear_tc(input logic [9:0] base);
		cyc(base + 10'h5, 1'b1, 8'h5a);
	endtask : clear_tc
endmodule : serial_card_host

//--- test_serial_card_ctrl_status_port.sv
// Purpose: Self-checking bench for the control/status port
// Assumes: Host model drives the bus at falling edges
// Notes: A watcher scores each read against a queue of notes
`timescale 1ns/1ps
module test_serial_card_ctrl_status_port;
	import serial_card_pkg::*;
	logic clk, rst_n, wr, rd, dsr, irq_n, tc, mode, rts;
	logic sel, cs, oe, dtr, drv, tci;
	logic [9:0] addr, base;
	logic [7:0] wd, rdat, w;
	logic [6:0] sw;
	logic [1:0] creg;
	logic [31:0] rng = 32'd49;
	dma_src_e src;
	logic [7:0] exp_q[$];
	int err_count = 0, checks_done = 0, cycles = 0;
	serial_card_host i_host (.i_core_clk(clk), .o_io_addr(addr),
		.o_io_wr(wr), .o_io_rd(rd), .o_io_wdata(wd));
	serial_card_ctrl_status_port i_dut (.i_core_clk(clk),
		.i_arst_n(rst_n), .i_io_addr(addr), .i_io_wr(wr),
		.i_io_rd(rd), .i_io_wdata(wd), .i_base_switch_open(sw),
		.i_dsr(dsr), .i_serial_ctrl_irq_n(irq_n), .i_dma_tc(tc),
		.i_irq_mode_select(mode), .i_dma_enable_source_select(src),
		.i_chan_b_rts(rts), .o_card_sel(sel), .o_serial_ctrl_cs(cs),
		.o_serial_ctrl_reg(creg), .o_io_rdata(rdat),
		.o_io_rdata_oe(oe), .o_dtr(dtr), .o_dma_drv_en(drv),
		.o_tc_interrupt(tci));
	function automatic logic [7:0] xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng[7:0];
	endfunction : xs
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic conclude();
		$display("checks=%0d errors=%0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : conclude
	task automatic rd_st(input logic [7:0] e);
		exp_q.push_back(e);
		i_host.cyc(base + 10'h4, 1'b0, 8'h00);
	endtask : rd_st
	task automatic chk_rd(input logic [7:0] got);
		if (exp_q.size() == 0) begin
			checks_done++;
			err_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, ~got);
		end else begin
			chk(got, exp_q.pop_front());
		end
	endtask : chk_rd
	// An unasked strobe finds no note and fails
	always @(negedge clk) if (oe === 1'b1)
		chk_rd(rdat);
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) if (++cycles == 3000) begin
		err_count++;
		conclude();
	end
	initial begin
		{rst_n, dsr, tc, mode, rts} = '0;
		irq_n = 1'b1;
		src = DMA_SRC_CSR_BIT;
		sw = 7'(xs());
		base = {sw, 3'b000};
		repeat (4) @(posedge clk);
		@(negedge clk) rst_n = 1'b1;
		chk(8'({dtr, drv}), 8'h00);
		for (int i = 0; i < 8; i++) begin
			// Reset status: DSR off, IRQ off, TC clear, DMA off
			if (i == 4) exp_q.push_back(8'ha9);
			fork
				i_host.cyc(base + 10'(i), 1'b0, 8'h00);
				begin
					@(negedge clk) #1;
					chk(8'({sel, cs, creg}), 8'({1'b1, i < 4, 2'(i)}));
				end
			join
		end
		for (int k = 0; k < 6; k++) begin
			w = xs();
			// DSR and controller IRQ lines move on their own
			{dsr, irq_n} = 2'(xs());
			i_host.cyc(base + 10'h4, 1'b1, w);
			@(negedge clk) chk(8'({dtr, drv}), 8'({w[0], w[7]}));
			rd_st({~w[7], 3'b010, irq_n, 2'b00, ~dsr});
		end
		for (int s = 0; s < 4; s++) begin
			src = dma_src_e'(s);
			rts = 1'(xs());
			@(negedge clk);
			chk(8'(drv), 8'(s == 3 || s == 2 && rts || s == 1 && w[7]));
		end
		src = DMA_SRC_CSR_BIT;
		$display("test decode and port done");
		// Mid-run reset with terminal ready, DMA enable and TC interrupt set
		i_host.cyc(base + 10'h4, 1'b1, 8'h81);
		{mode, tc} = 2'b11;
		@(negedge clk) {mode, tc} = 2'b00;
		chk(8'({dtr, drv, tci}), 8'h07);
		rst_n = 1'b0;
		@(negedge clk) chk(8'({dtr, drv, tci}), 8'h00);
		rst_n = 1'b1;
		$display("test mid-run reset done");
		i_host.cyc(base + 10'h4, 1'b1, 8'h00);
		mode = 1'b1;
		tc = 1'b1;
		@(negedge clk) tc = 1'b0;
		@(negedge clk) chk(8'(tci), 8'h01);
		rd_st({1'b1, 3'b000, irq_n, 2'b00, ~dsr});
		i_host.clear_tc(base);
		@(negedge clk) chk(8'(tci), 8'h00);
		mode = 1'b0;
		tc = 1'b1;
		@(negedge clk) tc = 1'b0;
		@(negedge clk) chk(8'(tci), 8'h00);
		// Offset 6 is refused, then a write and a read outside the window
		i_host.cyc(base + 10'h6, 1'b1, 8'h01);
		i_host.cyc((base ^ 10'h200) + 10'h4, 1'b1, 8'h01);
		i_host.cyc((base ^ 10'h200) + 10'h4, 1'b0, 8'h00);
		@(negedge clk) chk(8'(dtr), 8'h00);
		chk(8'(exp_q.size()), 8'h00);
		$display("test terminal count and base done");
		conclude();
	end
endmodule : test_serial_card_ctrl_status_port
